// *** pkg/sssc_map.svh ***
`ifndef SSSC_MAP_SVH
`define SSSC_MAP_SVH
// ************************************************
// command codes
// ************************************************
`define SSSC_MAIN_CODE      8'h27
`define SSSC_SUB_UDP_OPEN   8'h01
`define SSSC_SUB_UDP_RECV   8'h02
`define SSSC_SUB_UDP_SEND   8'h03
`define SSSC_SUB_UDP_CLOSE  8'h04
`define SSSC_SUB_TCP_OPENP  8'h10
`define SSSC_SUB_TCP_OPENA  8'h11
`define SSSC_SUB_TCP_RECV   8'h12
`define SSSC_SUB_TCP_SEND   8'h13
`define SSSC_SUB_TCP_CLOSE  8'h14
// ************************************************
// status word bits
// ************************************************
`define SSSC_BIT_OPENING    0
`define SSSC_BIT_RECEIVING  1
`define SSSC_BIT_SENDING    2
`define SSSC_BIT_CLOSING    3
`define SSSC_BIT_TCP        13
`define SSSC_BIT_RS_ERR     14
`define SSSC_BIT_OPEN       15
// ************************************************
// parameter limits and codes
// ************************************************
`define SSSC_HOST_PORT_DEF  16'h2580
`define SSSC_AREA_MEM       8'h01
`define SSSC_AREA_DM        8'h02
`define SSSC_AREA_EM        8'h03
`define SSSC_MEM_LAST       16'h01FF
`define SSSC_DM_LAST        16'h17FF
`define SSSC_RSP_OK         16'h0000
`define SSSC_RSP_RANGE      16'h1100
`define SSSC_RSP_AREA       16'h1101
`define SSSC_RSP_BITADDR    16'h1103
`define SSSC_RSP_ISOPEN     16'h220F
`define SSSC_RES_NOBUF      16'h003E
`define SSSC_RES_INUSE      16'h0049
// ************************************************
// apb register map (byte addresses)
// ************************************************
`define SSSC_A_CMD          12'h000
`define SSSC_A_PARAM0       12'h004
`define SSSC_A_PARAM1       12'h008
`define SSSC_A_RESP         12'h00C
`define SSSC_A_DONE         12'h010
`define SSSC_A_STAT0        12'h020
`define SSSC_A_HOSTPORT     12'h030
`define SSSC_A_BANKS        12'h034
`define SSSC_A_PORT0        12'h040
`define SSSC_A_RESULT       12'h050
`define SSSC_RST_BANKS      8'h01
`endif

// *** pkg/sssc_pkg.sv ***
package sssc_pkg;
   typedef enum logic [1:0] {SSSC_OP_OPEN, SSSC_OP_RECV, SSSC_OP_SEND, SSSC_OP_CLOSE} sssc_op_t;
   // one decoded host command
   typedef struct packed {
      logic       valid;
      sssc_op_t   op;
      logic       tcp;
      logic [1:0] sock;
   } sssc_cmd_t;
   // results storage designation
   typedef struct packed {
      logic [7:0]  area;
      logic [15:0] word;
      logic [7:0]  bitaddr;
      logic [3:0]  bank;
   } sssc_rsa_t;
   typedef enum logic [1:0] {SSSC_RSA_OK, SSSC_RSA_AREA, SSSC_RSA_BIT, SSSC_RSA_BANK} sssc_rsa_res_t;
endpackage

// *** hw/sssc_decode.sv ***
`timescale 1ns/1ns
`include "sssc_map.svh"
// combinational decode of main and sub request codes
module sssc_decode
(
   input  wire logic [7:0]       main_request_code,
   input  wire logic [7:0]       sub_request_code,
   input  wire logic [15:0]      sock_num,
   output sssc_pkg::sssc_cmd_t   cmd,
   output logic                  known,
   output logic                  sock_bad
);
   // code table lookup
   always_comb
   begin
      cmd      = '0;
      known    = 1'b0;
      sock_bad = (sock_num < 16'h0001) || (sock_num > 16'h0004);
      cmd.sock = 2'(sock_num - 16'h0001);
      if (main_request_code == `SSSC_MAIN_CODE)
      begin
         known = 1'b1;
         case (sub_request_code)
            `SSSC_SUB_UDP_OPEN:  cmd.op = sssc_pkg::SSSC_OP_OPEN;
            `SSSC_SUB_UDP_RECV:  cmd.op = sssc_pkg::SSSC_OP_RECV;
            `SSSC_SUB_UDP_SEND:  cmd.op = sssc_pkg::SSSC_OP_SEND;
            `SSSC_SUB_UDP_CLOSE: cmd.op = sssc_pkg::SSSC_OP_CLOSE;
            `SSSC_SUB_TCP_OPENP,
            `SSSC_SUB_TCP_OPENA:
            begin
               cmd.op  = sssc_pkg::SSSC_OP_OPEN;
               cmd.tcp = 1'b1;
            end
            `SSSC_SUB_TCP_RECV:
            begin
               cmd.op  = sssc_pkg::SSSC_OP_RECV;
               cmd.tcp = 1'b1;
            end
            `SSSC_SUB_TCP_SEND:
            begin
               cmd.op  = sssc_pkg::SSSC_OP_SEND;
               cmd.tcp = 1'b1;
            end
            `SSSC_SUB_TCP_CLOSE:
            begin
               cmd.op  = sssc_pkg::SSSC_OP_CLOSE;
               cmd.tcp = 1'b1;
            end
            default: known = 1'b0;
         endcase
      end
      cmd.valid = known;
   end
endmodule // sssc_decode

// *** hw/sssc_rsa_check.sv ***
`timescale 1ns/1ns
`include "sssc_map.svh"
// results storage area check
module sssc_rsa_check
(
   input  sssc_pkg::sssc_rsa_t      rsa,
   input  wire logic [15:0]         banks_fitted,
   output sssc_pkg::sssc_rsa_res_t  res
);
   always_comb
   begin
      res = sssc_pkg::SSSC_RSA_OK;
      if (rsa.bitaddr != 8'h00)
         res = sssc_pkg::SSSC_RSA_BIT;
      else if (rsa.area == `SSSC_AREA_MEM)
      begin
         if (rsa.word > `SSSC_MEM_LAST)
            res = sssc_pkg::SSSC_RSA_AREA;
      end
      else if (rsa.area == `SSSC_AREA_DM)
      begin
         if (rsa.word > `SSSC_DM_LAST)
            res = sssc_pkg::SSSC_RSA_AREA;
      end
      else if (rsa.area == `SSSC_AREA_EM)
      begin
         if (rsa.word > `SSSC_DM_LAST)
            res = sssc_pkg::SSSC_RSA_AREA;
         else if (!banks_fitted[rsa.bank])
            res = sssc_pkg::SSSC_RSA_BANK;
      end
      else
         res = sssc_pkg::SSSC_RSA_AREA;
   end
endmodule // sssc_rsa_check

// *** hw/sssc_top.sv ***
`timescale 1ns/1ns
`include "sssc_map.svh"
// socket service command interpreter with apb register access
module sssc_top
#(
   parameter int NSOCK = 4
)
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [15:0]      route_port_0,
   output logic [15:0]      route_port_1,
   output logic [15:0]      route_port_2,
   output logic [15:0]      route_port_3
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic [NSOCK-1:0][15:0] stat;
      logic [NSOCK-1:0][15:0] port;
      logic [NSOCK-1:0]       rs_pend;
      logic [31:0]            param0;
      logic [31:0]            param1;
      logic [31:0]            resp;
      logic [31:0]            result;
      logic [15:0]            host_port;
      logic [15:0]            banks;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
   } sssc_state_t;
   sssc_state_t st_reg;
   sssc_state_t st_next;

   sssc_pkg::sssc_cmd_t     cmd;
   logic                    known;
   logic                    sock_bad;
   sssc_pkg::sssc_rsa_t     rsa;
   sssc_pkg::sssc_rsa_res_t rsa_res;

   // command parameters: param0 = sock number | port, param1 = storage area
   assign rsa.area    = st_reg.param1[31:24];
   assign rsa.bank    = st_reg.param1[23:20];
   assign rsa.bitaddr = {4'h0, st_reg.param1[19:16]};
   assign rsa.word    = st_reg.param1[15:0];

   sssc_decode u_decode
   (
      .main_request_code (pwdata[15:8]),
      .sub_request_code  (pwdata[7:0]),
      .sock_num          (st_reg.param0[31:16]),
      .cmd               (cmd),
      .known             (known),
      .sock_bad          (sock_bad)
   );

   sssc_rsa_check u_rsa
   (
      .rsa          (rsa),
      .banks_fitted (st_reg.banks),
      .res          (rsa_res)
   );

   // true when any other open socket already owns this port
   function automatic logic port_in_use(input sssc_state_t s, input logic [1:0] me,
                                        input logic [15:0] p);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NSOCK; i++)
         if (i != int'(me) && s.stat[i][`SSSC_BIT_OPEN] && s.port[i] == p)
            hit = 1'b1;
      return hit;
   endfunction

   // true when no busy bit of a socket is set
   function automatic logic idle(input logic [15:0] w);
      return w[3:0] == 4'h0;
   endfunction

   logic access;
   logic wr;
   logic [15:0] lport;
   assign access = psel && penable;
   assign wr     = access && pwrite;
   assign lport  = st_reg.param0[15:0];

   // ************************************************
   // next state
   // ************************************************
   always_comb
   begin
      st_next         = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      // delayed storage error, raised only once the socket is idle
      for (int i = 0; i < NSOCK; i++)
      begin
         if (st_reg.rs_pend[i] && idle(st_reg.stat[i]))
         begin
            st_next.stat[i][`SSSC_BIT_RS_ERR] = 1'b1;
            st_next.rs_pend[i]                = 1'b0;
         end
      end
      if (psel && !st_reg.pready)
      begin
         // one wait state: answer in the cycle after penable rises
         st_next.pready = access;
      end
      if (access && !st_reg.pready)
      begin
         st_next.prdata = 32'h0000_0000;
         if (!wr)
         begin
            if (paddr == `SSSC_A_PARAM0)
               st_next.prdata = st_reg.param0;
            else if (paddr == `SSSC_A_PARAM1)
               st_next.prdata = st_reg.param1;
            else if (paddr == `SSSC_A_RESP)
               st_next.prdata = st_reg.resp;
            else if (paddr == `SSSC_A_RESULT)
               st_next.prdata = st_reg.result;
            else if (paddr == `SSSC_A_HOSTPORT)
               st_next.prdata = {16'h0000, st_reg.host_port};
            else if (paddr == `SSSC_A_BANKS)
               st_next.prdata = {16'h0000, st_reg.banks};
            else if (paddr[11:4] == 8'(`SSSC_A_STAT0 >> 4) && paddr[1:0] == 2'b00)
               st_next.prdata = {16'h0000, st_reg.stat[paddr[3:2]]};
            else if (paddr[11:4] == 8'(`SSSC_A_PORT0 >> 4) && paddr[1:0] == 2'b00)
               st_next.prdata = {16'h0000, st_reg.port[paddr[3:2]]};
            else if (paddr != `SSSC_A_CMD && paddr != `SSSC_A_DONE)
               st_next.pslverr = 1'b1;
         end
         else if (paddr == `SSSC_A_PARAM0)
            st_next.param0 = pwdata;
         else if (paddr == `SSSC_A_PARAM1)
            st_next.param1 = pwdata;
         else if (paddr == `SSSC_A_HOSTPORT)
            st_next.host_port = pwdata[15:0];
         else if (paddr == `SSSC_A_BANKS)
            st_next.banks = pwdata[15:0];
         else if (paddr == `SSSC_A_CMD)
         begin
            // command issue: check parameters then mark the socket busy
            st_next.resp = {16'h0000, `SSSC_RSP_OK};
            if (!known || sock_bad)
               st_next.resp = {16'h0000, `SSSC_RSP_RANGE};
            else if (cmd.op == sssc_pkg::SSSC_OP_OPEN && !cmd.tcp && lport == 16'h0000)
               st_next.resp = {16'h0000, `SSSC_RSP_RANGE};
            else if (rsa_res == sssc_pkg::SSSC_RSA_AREA)
               st_next.resp = {16'h0000, `SSSC_RSP_AREA};
            else if (rsa_res == sssc_pkg::SSSC_RSA_BIT)
               st_next.resp = {16'h0000, `SSSC_RSP_BITADDR};
            else if (cmd.op == sssc_pkg::SSSC_OP_OPEN
                     && (st_reg.stat[cmd.sock][`SSSC_BIT_OPEN]
                         || st_reg.stat[cmd.sock][`SSSC_BIT_OPENING]))
               st_next.resp = {16'h0000, `SSSC_RSP_ISOPEN};
            else
            begin
               st_next.stat[cmd.sock][`SSSC_BIT_RS_ERR] = 1'b0;
               st_next.rs_pend[cmd.sock] = (rsa_res == sssc_pkg::SSSC_RSA_BANK);
               st_next.stat[cmd.sock][int'(cmd.op)] = 1'b1;
               if (cmd.op == sssc_pkg::SSSC_OP_OPEN)
               begin
                  st_next.stat[cmd.sock][`SSSC_BIT_TCP] = cmd.tcp;
                  st_next.port[cmd.sock] = lport;
               end
            end
         end
         else if (paddr == `SSSC_A_DONE)
         begin
            // completion from the protocol engine: [1:0] socket, [3:2] op,
            // [4] error; the result word is stored in the same cycle as busy clears
            st_next.result = {16'h0000, `SSSC_RSP_OK};
            if (pwdata[2+:2] == 2'(sssc_pkg::SSSC_OP_OPEN))
            begin
               if (pwdata[4])
               begin
                  st_next.result = {16'h0000, `SSSC_RES_NOBUF};
                  st_next.port[pwdata[1:0]] = 16'h0000;           // failed open routes nothing
               end
               else if (!st_reg.stat[pwdata[1:0]][`SSSC_BIT_TCP]
                        && (st_reg.port[pwdata[1:0]] == st_reg.host_port
                            || port_in_use(st_reg, pwdata[1:0],
                                           st_reg.port[pwdata[1:0]])))
               begin
                  st_next.result = {16'h0000, `SSSC_RES_INUSE};
                  st_next.port[pwdata[1:0]] = 16'h0000;
               end
               else
                  st_next.stat[pwdata[1:0]][`SSSC_BIT_OPEN] = 1'b1;
            end
            else if (pwdata[2+:2] == 2'(sssc_pkg::SSSC_OP_CLOSE))
            begin
               st_next.stat[pwdata[1:0]][`SSSC_BIT_OPEN] = 1'b0;
               st_next.port[pwdata[1:0]] = 16'h0000;
            end
            st_next.stat[pwdata[1:0]][pwdata[2+:2]] = 1'b0;
         end
         else
            st_next.pslverr = 1'b1;
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg           <= '0;
         st_reg.host_port <= `SSSC_HOST_PORT_DEF;
         st_reg.banks     <= {8'h00, `SSSC_RST_BANKS};
      end
      else
         st_reg <= st_next;
   end

   // outputs straight from flip-flops; each socket's stored port, udp or tcp, steers routing from the open request on
   assign prdata  = st_reg.prdata;
   assign pready  = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign route_port_0 = st_reg.port[0];
   assign route_port_1 = st_reg.port[1];
   assign route_port_2 = st_reg.port[2];
   assign route_port_3 = st_reg.port[3];
endmodule // sssc_top

// *** verification/sssc_top_properties.sv ***
`timescale 1ns/1ns
`include "sssc_map.svh"
// ********
// port checks of the command interpreter
// ********
module sssc_top_properties
#(
   parameter int NSOCK = 4
)
(
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] route_port_0,
   input wire logic [15:0] route_port_1,
   input wire logic [15:0] route_port_2,
   input wire logic [15:0] route_port_3
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // answer cycles of interest
   wire logic st0_rd = pready && !pwrite && paddr == `SSSC_A_STAT0;
   wire logic wr_done = pready && pwrite;
   wire logic st_rd = pready && !pwrite && paddr[11:4] == 8'h02;

   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("ready not one cycle after access start");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(penable))
      else $error("ready outside an access phase");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   AST_UNMAPPED: assert property (pready && paddr[11:8] != 4'h0 |-> pslverr)
      else $error("unmapped access not refused");
   AST_STATUS_MAPPED: assert property (st_rd |-> !pslverr)
      else $error("status word read refused");
   AST_ERR_ONLY_IDLE: assert property (st0_rd && prdata[14] |-> prdata[3:0] == 4'h0)
      else $error("storage error shown while busy");
   AST_OPEN_PORT: assert property (st0_rd && !prdata[13] && !prdata[0]
      |-> prdata[15] == (route_port_0 != 16'h0000))
      else $error("open flag and routed port disagree");
   AST_ROUTE_ON_WRITE: assert property ($changed(route_port_0) |-> wr_done)
      else $error("routed port moved without a write");

   COV_REFUSED: cover property (pready && pslverr);
   COV_RS_ERR: cover property (st_rd && prdata[14]);
   COV_ROUTED: cover property (route_port_0 != 16'h0000);
endmodule // sssc_top_properties

bind sssc_top sssc_top_properties #(.NSOCK(NSOCK)) i_props
(
   .clock        (clock),
   .arst_n       (arst_n),
   .psel         (psel),
   .penable      (penable),
   .pwrite       (pwrite),
   .paddr        (paddr),
   .pwdata       (pwdata),
   .prdata       (prdata),
   .pready       (pready),
   .pslverr      (pslverr),
   .route_port_0 (route_port_0),
   .route_port_1 (route_port_1),
   .route_port_2 (route_port_2),
   .route_port_3 (route_port_3)
);

// *** verification/sssc_host_model.sv ***
`timescale 1ns/1ns
// ********
// host controller: apb master side
// ********
module sssc_host_model
(
   input  wire logic        clock,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // one transfer; waits as long as the slave needs
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // released data must not look valid
   endtask
endmodule // sssc_host_model

// *** verification/tb_sssc_top.sv ***
`timescale 1ns/1ns
`include "sssc_map.svh"
module tb_sssc_top;
   localparam logic [31:0] RSA_OK = 32'h01000010; // plain memory area, never auxiliary
   logic        clock;
   logic        arst_n;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] rp [4];
   int          err_count = 0;
   int          checked = 0;

   sssc_host_model i_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   sssc_top #(.NSOCK(4)) i_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .route_port_0(rp[0]), .route_port_1(rp[1]),
      .route_port_2(rp[2]), .route_port_3(rp[3]));

   // ********
   // helpers
   // ********
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      i_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      i_host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   // issue one command and judge the immediate answer
   task automatic cmd(input int s, input logic [7:0] sub, input logic [15:0] port,
                      input logic [31:0] rsa, input logic [15:0] rsp);
      logic [31:0] q;
      wr(`SSSC_A_PARAM0, {16'(s), port});
      wr(`SSSC_A_PARAM1, rsa);
      wr(`SSSC_A_CMD, {16'h0000, `SSSC_MAIN_CODE, sub});
      rd(`SSSC_A_RESP, q);
      check("response", q, {16'h0000, rsp});
   endtask
   task automatic stat(input int i, input logic [15:0] exp);
      logic [31:0] q;
      rd(12'(`SSSC_A_STAT0 + 4 * i), q);
      check("status", q, {16'h0000, exp});
   endtask
   task automatic done(input int i, input int op, input logic oerr);
      wr(`SSSC_A_DONE, {27'h0, oerr, 2'(op), 2'(i)});
   endtask

   // ********
   // scenarios
   // ********
   task automatic after_reset();
      logic [31:0] q;
      logic        e;
      rd(`SSSC_A_HOSTPORT, q);
      check("host port", q, 32'h00002580);
      for (int i = 0; i < 4; i++)
         stat(i, 16'h0000);
      i_host.xfer(1'b0, 12'h100, 32'h0, q, e);
      check("unmapped", {31'h0, e}, 32'h1);
   endtask
   // open, reopen, then receive, send and close; off is 10 for tcp
   task automatic life(input int i, input logic [7:0] osub, input logic [7:0] off,
                       input logic [15:0] port);
      logic [15:0] t;
      logic [15:0] o;
      logic [31:0] q;
      t = {2'b00, off[4], 13'h0000}; // socket kind, shown from the open request on
      o = t | 16'h8000;
      cmd(i + 1, osub, port, RSA_OK, 16'h0000);
      stat(i, t | 16'h0001);
      done(i, 0, 1'b0);
      stat(i, o);
      rd(12'(`SSSC_A_PORT0 + 4 * i), q);
      check("port", q, {16'h0, port});
      if (off == 8'h00)
         check("route", {16'h0, rp[i]}, {16'h0, port});
      cmd(i + 1, osub, port, RSA_OK, 16'h220F);
      for (int k = 1; k < 4; k++)
      begin
         cmd(i + 1, off + 8'(k + 1), port, RSA_OK, 16'h0000);
         stat(i, o | 16'(1 << k));
         done(i, k, 1'b0);
         stat(i, (k == 3) ? t : o);
      end
      check("route closed", {16'h0, rp[i]}, 32'h0);
   endtask
   task automatic refusals();
      cmd(0, 8'h01, 16'h1234, RSA_OK, 16'h1100);
      cmd(5, 8'h01, 16'h1234, RSA_OK, 16'h1100);
      cmd(1, 8'h01, 16'h0000, RSA_OK, 16'h1100);
      cmd(1, 8'h01, 16'h1234, 32'h04000010, 16'h1101);
      cmd(1, 8'h01, 16'h1234, 32'h01030010, 16'h1103);
      stat(0, 16'h0000);
   endtask
   // unfitted bank, failed open, then host port clash
   task automatic storage_errors();
      logic [31:0] q;
      cmd(4, 8'h01, 16'h3000, 32'h03200010, 16'h0000);
      stat(3, 16'h0001);
      done(3, 0, 1'b1);
      stat(3, 16'h4000);
      check("route failed", {16'h0, rp[3]}, 32'h0);
      rd(`SSSC_A_RESULT, q);
      check("result", q, 32'h0000003E);
      cmd(4, 8'h01, 16'h2580, RSA_OK, 16'h0000);
      stat(3, 16'h0001);
      done(3, 0, 1'b0);
      rd(`SSSC_A_RESULT, q);
      check("result", q, 32'h00000049);
      stat(3, 16'h0000);
      check("route in use", {16'h0, rp[3]}, 32'h0);
   endtask

   // ********
   // clock, reset, run
   // ********
   initial
      clock = 1'b0;
   always
      #2 clock = ~clock;
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog well above the expected several hundred cycles
   initial
   begin
      #80000;
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      arst_n = 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      after_reset();
      life(0, 8'h01, 8'h00, 16'h1234);
      life(1, 8'h10, 8'h10, 16'h0050);
      life(2, 8'h11, 8'h10, 16'h0051);
      refusals();
      storage_errors();
      tally_and_finish();
   end
endmodule // tb_sssc_top
